// ==== core/port_pkg.sv ====
// shared constants and types for the port mode and key wake block
//
// Function
// - key wake on port 0 bits 3..7, per-pin enable
// - enabled key low past machine cycle sets flag
// - hardware sets key flag, only software clears
// - key event wakes cpu from idle, power down
// - mode bits: quasi, push-pull, input, open drain
// - port 1 bit 5 input only, reset pin option
// - per-port select: schmitt or ttl inputs
// - tri-state during reset, then quasi mode
// - latches load reset level after reset
// - port 1 bit 5 schmitt input once out of reset
// - timer toggle enable flips pin per overflow
// - quasi: strong pull-up two clocks on rise
// - quasi: weak pull-up while pin reads one
// - quasi: very weak pull-up while latch one
// - open drain: no pull-ups, drive low only
// - push-pull: strong high or driven low
// - input only: no output drive at all
// - quasi pin is input and output, reads pin
// - clock out quarter cpu clock on port 2.0
package port_pkg;

   localparam int unsigned NUM_PORTS = 3;
   localparam int unsigned PORT_W    = 8;
   localparam int unsigned NUM_PINS  = NUM_PORTS * PORT_W;
   localparam int unsigned APB_AW    = 8;

   // ==========================================================
   // register byte offsets; per-port registers step by stride
   localparam logic [7:0] OFF_LATCH           = 8'h00;
   localparam logic [7:0] OFF_MODE_A          = 8'h0c;
   localparam logic [7:0] OFF_MODE_B          = 8'h18;
   localparam logic [7:0] PORT_STRIDE         = 8'h04;
   localparam logic [7:0] OFF_PORT_MODE_TWO_A = 8'h24;
   localparam logic [7:0] OFF_KEY_ENABLE      = 8'h28;
   localparam logic [7:0] OFF_AUX_CONTROL_ONE = 8'h2c;

   // ==========================================================
   // field positions and write masks
   localparam int unsigned SCHMITT_LSB          = 0;
   localparam int unsigned TIMER_ZERO_TOGGLE_EN = 3;
   localparam int unsigned TIMER_ONE_TOGGLE_EN  = 4;
   localparam int unsigned CLOCK_OUT_ENABLE     = 5;
   localparam logic [7:0]  PORT_MODE_TWO_A_MASK = 8'h3f;
   localparam int unsigned KEY_PIN_LSB          = 3;
   localparam int unsigned KEY_PINS             = 5;
   localparam int unsigned KEY_IRQ_EN_BIT       = 0;
   localparam logic [7:0]  KEY_ENABLE_MASK      = 8'hf9;
   localparam int unsigned KEY_FLAG_BIT         = 7;

   // ==========================================================
   // pin positions, as port * 8 + bit
   localparam int unsigned INPUT_ONLY_PIN = 13;
   localparam int unsigned TIMER_ZERO_PIN = 10;
   localparam int unsigned TIMER_ONE_PIN  = 11;
   localparam int unsigned CLOCK_OUT_PIN  = 16;

   // ==========================================================
   // mode codes as {pin_mode_bit_a, pin_mode_bit_b}
   localparam logic [1:0] MODE_QUASI = 2'h0;
   localparam logic [1:0] MODE_PUSH  = 2'h1;
   localparam logic [1:0] MODE_INPUT = 2'h2;
   localparam logic [1:0] MODE_OPEN  = 2'h3;
   localparam logic [1:0] CLK_SRC_RC  = 2'h1;
   localparam logic [1:0] CLK_SRC_EXT = 2'h3;

   // ==========================================================
   // timing, in cpu clocks
   localparam int unsigned MACHINE_CYCLE_CLKS = 4;
   localparam int unsigned KEY_LOW_CLKS       = MACHINE_CYCLE_CLKS + 1;
   localparam int unsigned STRONG_PULSE_CLKS  = 2;
   localparam int unsigned CLOCK_OUT_DIV      = 4;

   typedef struct packed {
      logic pull_low;
      logic strong_up;
      logic weak_up;
      logic very_weak_up;
   } pin_drv_s;

endpackage

// ==== core/pin_cell.sv ====
// one port pin: mode decode, pull-up sequencing and low drive
`timescale 1ns/1ns
`default_nettype none
module pin_cell (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [1:0]    mode,
   input  wire logic          latch,
   input  wire logic          pin_lvl,
   output var  port_pkg::pin_drv_s drv
);
   localparam logic [1:0] PULSE_LOAD =
      2'(port_pkg::STRONG_PULSE_CLKS - 1);

   logic       latch_q_r;
   logic [1:0] pulse_r;
   logic [1:0] pulse_nxt;

   wire logic quasi = mode == port_pkg::MODE_QUASI;
   wire logic push  = mode == port_pkg::MODE_PUSH;
   wire logic open  = mode == port_pkg::MODE_OPEN;
   wire logic rise  = latch & ~latch_q_r;

   assign pulse_nxt = rise ? PULSE_LOAD :
                      (pulse_r != 2'h0) ? pulse_r - 2'h1 : 2'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q_r <= 1'b0;
         pulse_r   <= 2'h0;
      end else begin
         latch_q_r <= latch;
         pulse_r   <= pulse_nxt;
      end
   end

   // input mode falls through every term and drives nothing
   always_comb begin
      drv.pull_low     = ~latch & (quasi | push | open);
      drv.strong_up    = latch & (push |
                         quasi & (rise | pulse_r != 2'h0));
      drv.weak_up      = quasi & pin_lvl;
      drv.very_weak_up = quasi & latch;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   strong_two_clk_a: assert property (
      (rise && quasi) ##1 (quasi && latch) ##1 (quasi && latch)
      |-> $past(drv.strong_up, 2) && $past(drv.strong_up) &&
          !drv.strong_up)
      else $error("strong pull-up not exactly two clocks");
   open_drain_a: assert property (
      open |-> !drv.strong_up && !drv.weak_up &&
               !drv.very_weak_up && drv.pull_low == !latch)
      else $error("open drain drive wrong");
   push_pull_a: assert property (
      push |-> drv.strong_up == latch && drv.pull_low == !latch &&
               !drv.weak_up && !drv.very_weak_up)
      else $error("push-pull drive wrong");
   input_only_a: assert property (
      mode == port_pkg::MODE_INPUT |-> drv == '0)
      else $error("input-only pin drives");
   quasi_pulls_a: assert property (
      quasi |-> drv.very_weak_up == latch && drv.weak_up == pin_lvl)
      else $error("quasi pull-ups wrong");
endmodule // pin_cell
`default_nettype wire

// ==== core/key_sync.sv ====
// key pin synchroniser and low-level qualification counter
`timescale 1ns/1ns
`default_nettype none
module key_sync #(
   parameter int unsigned LOW_CLKS = port_pkg::KEY_LOW_CLKS
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_raw,
   output var  logic hit
);
   localparam int unsigned   CW      = $clog2(LOW_CLKS + 1);
   localparam logic [CW-1:0] CNT_TOP = CW'(LOW_CLKS);

   logic          meta_r;
   logic          sync_r;
   logic [CW-1:0] cnt_r;

   // keys idle high, so the stages start high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         cnt_r  <= '0;
      end else begin
         meta_r <= pin_raw;
         sync_r <= meta_r;
         cnt_r  <= sync_r ? '0 :
                   (cnt_r == CNT_TOP) ? cnt_r : cnt_r + CW'(1);
      end
   end

   assign hit = cnt_r == CNT_TOP;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   low_qualify_a: assert property (
      (!sync_r)[*5] |=> hit)
      else $error("held low key not qualified");
   glitch_reject_a: assert property (
      sync_r |=> !hit)
      else $error("key hit without synchronised low");
endmodule // key_sync
`default_nettype wire

// ==== core/port_block.sv ====
// three-port pin controller with key wake, apb register file
`timescale 1ns/1ns
`default_nettype none
module port_block #(
   parameter int unsigned NPORT    = port_pkg::NUM_PORTS,
   parameter int unsigned KEY_LOW  = port_pkg::KEY_LOW_CLKS
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output var  logic [31:0]            prdata,
   output var  logic                   pready,
   output var  logic                   pslverr,
   input  wire logic [NPORT*8-1:0]     pin_in,
   output var  logic [NPORT*8-1:0]     pin_out,
   output var  logic [NPORT*8-1:0]     pin_oe,
   output var  logic [NPORT*8-1:0]     weak_up,
   output var  logic [NPORT*8-1:0]     very_weak_up,
   output var  logic [NPORT*8-1:0]     schmitt_sel,
   input  wire logic                   reset_level_high,
   input  wire logic                   reset_pin_disable,
   input  wire logic [1:0]             clk_src,
   input  wire logic                   t0_ovf,
   input  wire logic                   t1_ovf,
   output var  logic                   reset_pin_active,
   output var  logic                   key_irq,
   output var  logic                   key_wake
);
   localparam int unsigned NPIN = NPORT * port_pkg::PORT_W;
   localparam int unsigned DIVW = $clog2(port_pkg::CLOCK_OUT_DIV);
   localparam int unsigned KLSB = port_pkg::KEY_PIN_LSB;
   localparam int unsigned KN   = port_pkg::KEY_PINS;

   // ==========================================================
   // state
   logic [NPIN-1:0]  latch_r;
   logic [NPIN-1:0]  latch_nxt;
   logic [NPIN-1:0]  mode_a_r;
   logic [NPIN-1:0]  mode_a_nxt;
   logic [NPIN-1:0]  mode_b_r;
   logic [NPIN-1:0]  mode_b_nxt;
   logic [7:0]       pmode2_r;
   logic [7:0]       pmode2_nxt;
   logic [7:0]       key_en_r;
   logic [7:0]       key_en_nxt;
   logic             key_flag_r;
   logic             key_flag_nxt;
   logic             init_done_r;
   logic [DIVW-1:0]  clk_div_r;
   logic [31:0]      rd_val;
   logic             mapped;

   // ==========================================================
   // outputs held in flip-flops
   logic [NPIN-1:0]  out_nxt;
   logic [NPIN-1:0]  oe_nxt;
   logic [NPIN-1:0]  weak_nxt;
   logic [NPIN-1:0]  vweak_nxt;
   logic [NPIN-1:0]  schmitt_nxt;

   port_pkg::pin_drv_s [NPIN-1:0] drv;
   logic [NPIN-1:0][1:0]          eff_mode;
   logic [NPIN-1:0]               eff_latch;
   logic [KN-1:0]                 key_hit;

   // ==========================================================
   // apb slave: setup, one wait cycle, then completion
   wire logic access  = psel & penable;
   wire logic first   = access & ~pready;
   wire logic wr_en   = access & pwrite & pready;
   wire logic wr_pm2  = wr_en &
                        (paddr == port_pkg::OFF_PORT_MODE_TWO_A);
   wire logic wr_key  = wr_en & (paddr == port_pkg::OFF_KEY_ENABLE);
   wire logic wr_aux  = wr_en &
                        (paddr == port_pkg::OFF_AUX_CONTROL_ONE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= first;
         pslverr <= first & ~mapped;
         if (first) begin
            prdata <= mapped ? rd_val : '0;
         end
      end
   end

   // ==========================================================
   // per-port registers: latch, mode bit a, mode bit b
   always_comb begin
      latch_nxt  = latch_r;
      mode_a_nxt = mode_a_r;
      mode_b_nxt = mode_b_r;
      rd_val     = '0;
      mapped     = 1'b0;
      for (int p = 0; p < NPORT; p++) begin
         if (paddr == 8'(port_pkg::OFF_LATCH +
                         p * port_pkg::PORT_STRIDE)) begin
            mapped      = 1'b1;
            rd_val[7:0] = pin_in[p*8 +: 8];
            if (wr_en) begin
               latch_nxt[p*8 +: 8] = pwdata[7:0];
            end
         end
         if (paddr == 8'(port_pkg::OFF_MODE_A +
                         p * port_pkg::PORT_STRIDE)) begin
            mapped      = 1'b1;
            rd_val[7:0] = mode_a_r[p*8 +: 8];
            if (wr_en) begin
               mode_a_nxt[p*8 +: 8] = pwdata[7:0];
            end
         end
         if (paddr == 8'(port_pkg::OFF_MODE_B +
                         p * port_pkg::PORT_STRIDE)) begin
            mapped      = 1'b1;
            rd_val[7:0] = mode_b_r[p*8 +: 8];
            if (wr_en) begin
               mode_b_nxt[p*8 +: 8] = pwdata[7:0];
            end
         end
      end
      if (paddr == port_pkg::OFF_PORT_MODE_TWO_A) begin
         mapped      = 1'b1;
         rd_val[7:0] = pmode2_r;
      end
      if (paddr == port_pkg::OFF_KEY_ENABLE) begin
         mapped      = 1'b1;
         rd_val[7:0] = key_en_r;
      end
      if (paddr == port_pkg::OFF_AUX_CONTROL_ONE) begin
         mapped                         = 1'b1;
         rd_val[port_pkg::KEY_FLAG_BIT] = key_flag_r;
      end
      // a timer toggle wins over a software write in the same cycle
      if (pmode2_r[port_pkg::TIMER_ZERO_TOGGLE_EN] & t0_ovf) begin
         latch_nxt[port_pkg::TIMER_ZERO_PIN] =
            ~latch_r[port_pkg::TIMER_ZERO_PIN];
      end
      if (pmode2_r[port_pkg::TIMER_ONE_TOGGLE_EN] & t1_ovf) begin
         latch_nxt[port_pkg::TIMER_ONE_PIN] =
            ~latch_r[port_pkg::TIMER_ONE_PIN];
      end
      if (!init_done_r) begin
         latch_nxt = {NPIN{reset_level_high}};
      end
   end

   assign pmode2_nxt = wr_pm2 ?
      pwdata[7:0] & port_pkg::PORT_MODE_TWO_A_MASK : pmode2_r;
   assign key_en_nxt = wr_key ?
      pwdata[7:0] & port_pkg::KEY_ENABLE_MASK : key_en_r;

   // modes reset to zero, which is quasi-bidirectional
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_r     <= '0;
         mode_a_r    <= '0;
         mode_b_r    <= '0;
         pmode2_r    <= '0;
         key_en_r    <= '0;
         init_done_r <= 1'b0;
      end else begin
         latch_r     <= latch_nxt;
         mode_a_r    <= mode_a_nxt;
         mode_b_r    <= mode_b_nxt;
         pmode2_r    <= pmode2_nxt;
         key_en_r    <= key_en_nxt;
         init_done_r <= 1'b1;
      end
   end

   // ==========================================================
   // clock out: free-running divider, quarter of pclk
   wire logic src_ok     = (clk_src == port_pkg::CLK_SRC_RC) |
                           (clk_src == port_pkg::CLK_SRC_EXT);
   wire logic clk_out_on =
      pmode2_r[port_pkg::CLOCK_OUT_ENABLE] & src_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_div_r <= '0;
      end else begin
         clk_div_r <= clk_div_r + DIVW'(1);
      end
   end

   // ==========================================================
   // pin cells
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      if (i == port_pkg::INPUT_ONLY_PIN) begin : g_in
         assign eff_mode[i]  = port_pkg::MODE_INPUT;
         assign eff_latch[i] = latch_r[i];
      end else if (i == port_pkg::CLOCK_OUT_PIN) begin : g_ck
         assign eff_mode[i]  = clk_out_on ? port_pkg::MODE_PUSH :
                               {mode_a_r[i], mode_b_r[i]};
         assign eff_latch[i] = clk_out_on ? clk_div_r[DIVW-1] :
                               latch_r[i];
      end else begin : g_io
         assign eff_mode[i]  = {mode_a_r[i], mode_b_r[i]};
         assign eff_latch[i] = latch_r[i];
      end
      pin_cell u_cell (
         .pclk    (pclk),
         .presetn (presetn),
         .mode    (eff_mode[i]),
         .latch   (eff_latch[i]),
         .pin_lvl (pin_in[i]),
         .drv     (drv[i])
      );
   end

   // pins stay released until the reset level is loaded
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         out_nxt[i]   = init_done_r & drv[i].strong_up;
         oe_nxt[i]    = init_done_r &
                        (drv[i].strong_up | drv[i].pull_low);
         weak_nxt[i]  = init_done_r & drv[i].weak_up;
         vweak_nxt[i] = init_done_r & drv[i].very_weak_up;
      end
      for (int p = 0; p < NPORT; p++) begin
         schmitt_nxt[p*8 +: 8] =
            {8{pmode2_r[port_pkg::SCHMITT_LSB + p]}};
      end
      schmitt_nxt[port_pkg::INPUT_ONLY_PIN] = 1'b1;
   end

   // ==========================================================
   // key wake
   for (genvar k = 0; k < KN; k++) begin : g_key
      key_sync #(.LOW_CLKS(KEY_LOW)) u_sync (
         .pclk    (pclk),
         .presetn (presetn),
         .pin_raw (pin_in[KLSB + k]),
         .hit     (key_hit[k])
      );
   end

   wire logic key_set = |(key_hit & key_en_r[KLSB +: KN]);
   wire logic key_clr = wr_aux & ~pwdata[port_pkg::KEY_FLAG_BIT];
   // a set in the clearing cycle wins, so no key press is lost
   assign key_flag_nxt = key_set | (key_flag_r & ~key_clr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_flag_r       <= 1'b0;
         key_irq          <= 1'b0;
         key_wake         <= 1'b0;
         reset_pin_active <= 1'b0;
         pin_out          <= '0;
         pin_oe           <= '0;
         weak_up          <= '0;
         very_weak_up     <= '0;
         schmitt_sel      <= '0;
      end else begin
         key_flag_r       <= key_flag_nxt;
         key_irq          <= key_flag_nxt &
                             key_en_r[port_pkg::KEY_IRQ_EN_BIT];
         key_wake         <= key_flag_nxt & ~key_flag_r;
         reset_pin_active <= ~reset_pin_disable;
         pin_out          <= out_nxt;
         pin_oe           <= oe_nxt;
         weak_up          <= weak_nxt;
         very_weak_up     <= vweak_nxt;
         schmitt_sel      <= schmitt_nxt;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence key_press_s;
      key_set && !key_flag_r;
   endsequence

   sequence flag_then_wake_s;
      key_flag_r && key_wake;
   endsequence

   key_set_a: assert property (
      key_press_s |=> flag_then_wake_s)
      else $error("key press did not set flag and wake");
   key_hold_a: assert property (
      key_flag_r && !key_clr |=> key_flag_r)
      else $error("key flag dropped without software clear");
   key_clear_a: assert property (
      key_flag_r && key_clr && !key_set |=> !key_flag_r)
      else $error("key flag not cleared by write of zero");
   key_enable_a: assert property (
      !key_flag_r && !(|(key_hit & key_en_r[KLSB +: KN]))
      |=> !key_flag_r)
      else $error("key flag set by a disabled pin");
   key_irq_a: assert property (
      key_flag_r && $past(key_en_r[port_pkg::KEY_IRQ_EN_BIT])
      |-> key_irq)
      else $error("enabled key interrupt not requested");
   wake_pulse_a: assert property (
      key_wake |-> key_flag_r && !$past(key_flag_r))
      else $error("wake without a new key event");
   tristate_a: assert property (
      $rose(init_done_r) |-> pin_oe == '0 && weak_up == '0 &&
                             mode_a_r == '0 && mode_b_r == '0)
      else $error("pins not released through reset");
   reset_level_a: assert property (
      $rose(init_done_r) |->
         latch_r == {NPIN{$past(reset_level_high)}})
      else $error("latches not loaded with reset level");
   input_only_pin_a: assert property (
      !pin_oe[port_pkg::INPUT_ONLY_PIN] and
      (init_done_r |=> schmitt_sel[port_pkg::INPUT_ONLY_PIN]))
      else $error("input-only pin misconfigured");
   toggle_zero_a: assert property (
      init_done_r && t0_ovf &&
      pmode2_r[port_pkg::TIMER_ZERO_TOGGLE_EN]
      |=> latch_r[port_pkg::TIMER_ZERO_PIN] !=
          $past(latch_r[port_pkg::TIMER_ZERO_PIN]))
      else $error("timer zero overflow did not toggle pin");
   schmitt_a: assert property (
      ##1 schmitt_sel[0] == $past(pmode2_r[port_pkg::SCHMITT_LSB]))
      else $error("port zero input type not applied");
   clock_out_a: assert property (
      (init_done_r && clk_out_on)[*4]
      |-> pin_oe[port_pkg::CLOCK_OUT_PIN] &&
          pin_out[port_pkg::CLOCK_OUT_PIN] !=
          $past(pin_out[port_pkg::CLOCK_OUT_PIN], 2))
      else $error("clock out not a quarter of pclk");

endmodule // port_block
`default_nettype wire

// ==== bench/key_pad.sv ====
// partner model: key switches and loads on the port pins
`timescale 1ns/1ns
`default_nettype none
module key_pad (
   input  wire logic        pclk,
   input  wire logic [23:0] key_low,
   input  wire logic [23:0] pin_out,
   input  wire logic [23:0] pin_oe,
   input  wire logic [23:0] weak_up,
   input  wire logic [23:0] very_weak_up,
   output var  logic [23:0] pin_in
);
   logic flt_r = 1'b0;
   // an undriven, unpulled pin wanders instead of keeping its last level
   always @(posedge pclk) flt_r <= ~flt_r;
   // closed keys ground an undriven pin; a high comes from a drive, a pull or the wander
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~key_low
                   & (weak_up | very_weak_up | {24{flt_r}}));
endmodule // key_pad
`default_nettype wire

// ==== bench/tb_port_mode_and_key_wake.sv ====
// testbench for the port mode and key wake block
`timescale 1ns/1ns
`default_nettype none
module tb_port_mode_and_key_wake;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        t0_ovf, t1_ovf, rlh, pin_dis, rst_act, key_irq, key_wake;
   logic [1:0]  clk_src;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [23:0] pin_in, pin_out, pin_oe, weak_up, very_weak_up, schmitt_sel;
   logic [23:0] key_low;
   logic [8:0]  expq[$], rx;
   logic [31:0] seed = 32'h54;
   logic [3:0]  mtab [2][4] = '{'{4'h8, 4'h8, 4'h0, 4'h8},
                                '{4'h3, 4'hc, 4'h0, 4'h0}};
   int          failures = 0, n_tests = 0, wakes = 0, k;

   port_block dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .weak_up(weak_up),
      .very_weak_up(very_weak_up), .schmitt_sel(schmitt_sel),
      .reset_level_high(rlh), .reset_pin_disable(pin_dis), .clk_src(clk_src),
      .t0_ovf(t0_ovf), .t1_ovf(t1_ovf), .reset_pin_active(rst_act),
      .key_irq(key_irq), .key_wake(key_wake));
   key_pad pad (.pclk(pclk), .key_low(key_low), .pin_out(pin_out),
      .pin_oe(pin_oe), .weak_up(weak_up), .very_weak_up(very_weak_up),
      .pin_in(pin_in));

   // ==========================================================
   // helpers
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input logic [32:0] g, input logic [32:0] e, input string m);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // read expectation is {pslverr, data byte}
   task apb(input logic w, input logic [7:0] a, d, input logic [8:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      if (!w) expq.push_back(e);
      // no fixed wait count: the watchdog ends a slave that never answers
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ==========================================================
   // clock, watchdog, monitor
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #200000;
      failures++;
      print_verdict;
   end
   always @(posedge pclk) begin
      if (key_wake === 1'b1) wakes++;
      if (psel && penable && !pwrite && pready === 1'b1) begin
         rx = expq.pop_front();
         chk({pslverr, prdata}, {rx[8], 24'h0, rx[7:0]}, "read");
      end
   end

   // ==========================================================
   // scenarios
   initial begin
      {psel, penable, pwrite, t0_ovf, t1_ovf, pin_dis, presetn} = '0;
      {paddr, pwdata, key_low} = '0;
      rlh = 1'b1;
      clk_src = 2'h1;
      cyc(10);
      chk(pin_oe | weak_up | very_weak_up, 0, "tri-state in reset");
      cyc(10);
      presetn <= 1'b1;
      cyc(10);
      chk(very_weak_up[7:0], 8'hff, "quasi latch high");
      chk({pin_oe[7:0], rst_act}, 9'h001, "reset state");
      $display("reset test over");
      for (int l = 1; l >= 0; l--) begin
         for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h00, {7'h7f, l[0]}, 9'h0);
            apb(1'b1, 8'h0c, {7'h0, m[1]}, 9'h0);
            apb(1'b1, 8'h18, {7'h0, m[0]}, 9'h0);
            cyc(6);
            chk({pin_oe[0], pin_out[0], weak_up[0], very_weak_up[0]},
                mtab[l][m], "mode drive");
         end
      end
      apb(1'b1, 8'h0c, 8'h00, 9'h0);
      apb(1'b1, 8'h18, 8'h00, 9'h0);
      apb(1'b1, 8'h00, 8'hff, 9'h0);
      k = 0;
      // pin_out shows only the strong pull-up; pin_oe also covers pull low
      repeat (8) begin
         @(posedge pclk);
         k += (pin_out[0] === 1'b1);
      end
      chk(k, 2, "strong pulse length");
      $display("mode test over");
      apb(1'b1, 8'h24, 8'h21, 9'h0);
      cyc(4);
      chk(schmitt_sel[15:0], 16'h20ff, "schmitt select");
      k = 0;
      repeat (8) begin
         @(posedge pclk);
         k += (pin_out[16] === 1'b1);
      end
      chk(k, 4, "clock out quarter rate");
      clk_src <= 2'h2;
      cyc(6);
      chk({pin_oe[16], pin_out[16]}, 2'h0, "clock out source gate");
      clk_src <= 2'h3;
      cyc(2);
      chk(pin_oe[16], 1'b1, "clock out external source");
      apb(1'b1, 8'h24, 8'h18, 9'h0);
      t0_ovf <= 1'b1;
      t1_ovf <= 1'b1;
      @(posedge pclk);
      t0_ovf <= 1'b0;
      t1_ovf <= 1'b0;
      cyc(4);
      chk({pin_oe[11:10], pin_out[11:10]}, 4'hc, "timer toggle");
      repeat (4) begin
         seed = xs();
         apb(1'b1, 8'h08, seed[7:0], 9'h0);
         cyc(6);
         apb(1'b0, 8'h08, 8'h00, {1'b0, seed[7:0]});
      end
      apb(1'b0, 8'h30, 8'h00, 9'h100);
      $display("pin function test over");
      apb(1'b1, 8'h28, 8'h09, 9'h0);
      key_low <= 24'h18;
      cyc(3);
      key_low <= 24'h10;
      cyc(20);
      key_low <= 24'h0;
      chk(wakes, 0, "short or disabled key ignored");
      apb(1'b0, 8'h2c, 8'h00, 9'h000);
      key_low <= 24'h08;
      k = 0;
      while (wakes == 0 && k < 30) begin
         @(posedge pclk);
         k++;
      end
      chk({wakes[1:0], key_irq}, 3'h3, "key wake and irq");
      key_low <= 24'h0;
      cyc(4);
      apb(1'b0, 8'h2c, 8'h00, 9'h080);
      apb(1'b1, 8'h2c, 8'h00, 9'h0);
      apb(1'b0, 8'h2c, 8'h00, 9'h000);
      chk(key_irq, 0, "flag cleared");
      $display("key test over");
      print_verdict;
   end
endmodule // tb_port_mode_and_key_wake
`default_nettype wire
